// File: common/ashp_defs.svh
// Constants for the converter serial host port
`ifndef ASHP_DEFS_SVH
`define ASHP_DEFS_SVH
`define ASHP_WORD_W        8
`define ASHP_DATA_W        24
`define ASHP_FIFO_DEPTH    8
`define ASHP_AUX1_BIT      4
`define ASHP_AUX0_BIT      3
`define ASHP_SEL_LSB       4
`define ASHP_SEL_W         3
`define ASHP_RW_BIT        3
`define ASHP_SEL_DATA      3'h3
`define ASHP_RST_LOW_NS    100
`define ASHP_CLK_NS        50
`define ASHP_RST_CYC       ((`ASHP_RST_LOW_NS + `ASHP_CLK_NS - 1) / `ASHP_CLK_NS)
`define ASHP_MCLK_TMO      64
`define ASHP_REFRESH_CYC   32
`endif

// File: common/ashp_pkg.sv
// Types for the converter serial host port
package ashp_pkg;
    typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD} ashp_phase_t;

    typedef struct packed {
        logic       csn;
        logic       sclk;
        logic       din;
        logic [1:0] aux;
        logic       mclk;
        logic       rst_n;
    } ashp_pins_t;

    typedef struct packed {
        logic [2:0] sel;
        logic [7:0] data;
    } ashp_wr_t;
endpackage

// File: core/ashp_fifo.sv
// Small valid/ready FIFO for register writes
`timescale 1ns/1ps
module ashp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } ashp_fifo_st_t;

    logic [W-1:0]  mem_r [D];
    ashp_fifo_st_t st_r;
    ashp_fifo_st_t st_nxt;
    logic          push;
    logic          pop;

    assign in_ready_o  = (st_r.cnt != (AW+1)'(D));
    assign out_valid_o = (st_r.cnt != '0);
    assign out_data_o  = mem_r[st_r.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = (st_r.wp == AW'(D-1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(D-1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
        if (push) begin
            mem_r[st_r.wp] <= in_data_i;
        end
    end

    a_fifo_no_overfill: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_r.cnt <= (AW+1)'(D)) else $error("fifo count above depth");
endmodule

// File: core/ashp_port.sv
// Serial host port of a sigma-delta converter: framing, shifting, ready flag
// Function
// - Read data changes on the falling serial clock edge.
// - Clock idles high; idling low allowed with chip select framing, edges swap.
// - Ready output returns high after the first read of a new word.
// - Same word may be read again while ready is high.
// - Auxiliary inputs captured on first falling clock edge of a data read.
// - Auxiliary input 1 lands in bit 4, input 0 in bit 3.
// - Interface active only with chip select low; tied low gives three-wire mode.
// - Chip select selects the device or frames a continuous clock.
// - Reset low returns control and interface logic to power-on state; here only phase, bit count, output enable and ready reset, queued writes stay.
// - Reset exits only with reset high and master clock toggling.
// - Doubled master clock rates allowed only with the doubling bit set.
// - Crystal mode never drives internal clock on the clock output.
// - Ready output goes low when a new word sits in the data register.
// - Serial input shifts in, then moves to the register the selector names; here a write arriving with the write queue full is dropped.
`timescale 1ns/1ps
`include "ashp_defs.svh"
module ashp_port #(
    parameter int DATA_W     = `ASHP_DATA_W,
    parameter int FIFO_DEPTH = `ASHP_FIFO_DEPTH
) (
    // System
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // Host pins
    input  wire logic              cs_n_i,
    input  wire logic              sclk_i,
    input  wire logic              din_i,
    output logic                   dout_o,
    output logic                   dout_oe_o,
    output logic                   ready_n_o,
    // Auxiliary digital inputs
    input  wire logic              aux_input_0_i,
    input  wire logic              aux_input_1_i,
    // Master clock and reset pins
    input  wire logic              master_clock_in_i,
    input  wire logic              reset_n_i,
    input  wire logic              crystal_mode_i,
    input  wire logic              double_clock_select_i,
    output logic                   crystal_drive_out_o,
    output logic                   in_reset_o,
    // Converter side
    input  wire logic              word_valid_i,
    input  wire logic [DATA_W-1:0] word_data_i,
    output logic                   wr_valid_o,
    input  wire logic              wr_ready_i,
    output logic [2:0]             wr_sel_o,
    output logic [7:0]             wr_data_o
);
    typedef struct packed {
        ashp_pkg::ashp_pins_t  s1;
        ashp_pkg::ashp_pins_t  s2;
        logic                  sclk_d;
        logic                  mclk_d;
        logic                  csn_d;
        logic [6:0]            mclk_tmo;
        logic [3:0]            rst_cnt;
        logic                  in_rst;
        ashp_pkg::ashp_phase_t phase;
        logic                  idle_low;
        logic                  first_edge;
        logic [4:0]            bit_cnt;
        logic [7:0]            sh_in;
        logic [DATA_W-1:0]     sh_out;
        logic [DATA_W-1:0]     data_reg;
        logic                  fresh;
        logic                  read_once;
        logic [5:0]            refresh;
        logic                  dout;
        logic                  oe;
        logic [2:0]            sel;
        logic                  push;
        ashp_pkg::ashp_wr_t    wr;
        logic                  xtal_out;
    } ashp_st_t;

    ashp_st_t st_r;
    ashp_st_t st_nxt;
    logic     fifo_ready;
    logic     fifo_valid;
    logic [10:0] fifo_q;

    function automatic logic edge_of(input logic now, input logic prev, input logic rise);
        edge_of = rise ? (now && !prev) : (!now && prev);
    endfunction

    // Word with aux levels merged in
    function automatic logic [DATA_W-1:0] merge_aux(input logic [DATA_W-1:0] w,
                                                    input logic [1:0] aux);
        logic [DATA_W-1:0] r;
        r = w;
        r[`ASHP_AUX1_BIT] = aux[1];
        r[`ASHP_AUX0_BIT] = aux[0];
        merge_aux = r;
    endfunction

    logic drive_edge;
    logic sample_edge;
    logic active;
    logic mclk_toggle;

    always_comb begin
        st_nxt = st_r;
        drive_edge  = 1'b0;
        sample_edge = 1'b0;
        active      = 1'b0;
        mclk_toggle = 1'b0;
        st_nxt.push = 1'b0;
        // Two-stage sync of every pin except crystal mode and clock doubling
        st_nxt.s1 = '{csn: cs_n_i, sclk: sclk_i, din: din_i,
                      aux: {aux_input_1_i, aux_input_0_i},
                      mclk: master_clock_in_i, rst_n: reset_n_i};
        st_nxt.s2     = st_r.s1;
        st_nxt.sclk_d = st_r.s2.sclk;
        st_nxt.mclk_d = st_r.s2.mclk;
        st_nxt.csn_d  = st_r.s2.csn;

        // Master clock must be toggling to leave reset
        mclk_toggle = st_r.s2.mclk != st_r.mclk_d;
        if (mclk_toggle) begin
            st_nxt.mclk_tmo = '0;
        end else if (st_r.mclk_tmo != 7'(`ASHP_MCLK_TMO)) begin
            st_nxt.mclk_tmo = st_r.mclk_tmo + 7'h1;
        end
        // Reset input held low for at least the minimum pulse
        if (!st_r.s2.rst_n) begin
            st_nxt.rst_cnt = (st_r.rst_cnt == 4'(`ASHP_RST_CYC)) ? st_r.rst_cnt
                                                                 : st_r.rst_cnt + 4'h1;
            if (st_r.rst_cnt == 4'(`ASHP_RST_CYC)) begin
                st_nxt.in_rst = 1'b1;
            end
        end else begin
            st_nxt.rst_cnt = '0;
            if (st_r.in_rst && st_r.mclk_tmo != 7'(`ASHP_MCLK_TMO)) begin
                st_nxt.in_rst = 1'b0;
            end
        end
        // Crystal mode keeps internal clock off the output pin
        st_nxt.xtal_out = crystal_mode_i ? 1'b0 : st_r.s2.mclk;

        // Idle level latched at chip select fall
        active = !st_r.s2.csn && !st_r.in_rst;
        if (!st_r.s2.csn && st_r.csn_d) begin
            st_nxt.idle_low = !st_r.s2.sclk;
        end
        // Tied-low select sees one fall only, just after system reset, so the clock level then sets the roles
        drive_edge  = edge_of(st_r.s2.sclk, st_r.sclk_d, st_r.idle_low);
        sample_edge = edge_of(st_r.s2.sclk, st_r.sclk_d, !st_r.idle_low);

        // New conversion word lands in the data register
        if (word_valid_i) begin
            st_nxt.data_reg  = word_data_i;
            st_nxt.fresh     = 1'b1;
            st_nxt.read_once = 1'b0;
            st_nxt.refresh   = '0;
        end else if (!st_r.fresh && st_r.refresh != 6'(`ASHP_REFRESH_CYC)) begin
            st_nxt.refresh = st_r.refresh + 6'h1;
        end

        if (!active) begin
            st_nxt.phase   = ashp_pkg::ST_CMD;
            st_nxt.bit_cnt = '0;
            st_nxt.oe      = 1'b0;
        end else begin
            case (st_r.phase)
                ashp_pkg::ST_CMD: begin
                    if (sample_edge) begin
                        st_nxt.sh_in   = {st_r.sh_in[6:0], st_r.s2.din};
                        st_nxt.bit_cnt = st_r.bit_cnt + 5'h1;
                        if (st_r.bit_cnt == 5'd7) begin
                            st_nxt.bit_cnt    = '0;
                            st_nxt.sel        = st_r.sh_in[`ASHP_SEL_LSB-1 +: `ASHP_SEL_W];
                            st_nxt.first_edge = 1'b1;
                            st_nxt.sh_out     = st_r.data_reg;
                            if (st_r.sh_in[`ASHP_RW_BIT-1]) begin
                                st_nxt.phase = ashp_pkg::ST_RD;
                            end else begin
                                st_nxt.phase = ashp_pkg::ST_WR;
                            end
                        end
                    end
                end
                ashp_pkg::ST_WR: begin
                    if (sample_edge) begin
                        st_nxt.sh_in   = {st_r.sh_in[6:0], st_r.s2.din};
                        st_nxt.bit_cnt = st_r.bit_cnt + 5'h1;
                        if (st_r.bit_cnt == 5'd7) begin
                            st_nxt.push    = fifo_ready;
                            st_nxt.wr      = '{sel: st_r.sel,
                                               data: {st_r.sh_in[6:0], st_r.s2.din}};
                            st_nxt.phase   = ashp_pkg::ST_CMD;
                            st_nxt.bit_cnt = '0;
                        end
                    end
                end
                ashp_pkg::ST_RD: begin
                    if (drive_edge) begin
                        st_nxt.oe = 1'b1;
                        if (st_r.first_edge) begin
                            st_nxt.first_edge = 1'b0;
                            // Aux levels frozen into the outgoing word
                            st_nxt.sh_out = merge_aux(st_r.data_reg, st_r.s2.aux);
                            st_nxt.dout   = st_r.data_reg[DATA_W-1];
                        end else begin
                            st_nxt.sh_out = {st_r.sh_out[DATA_W-2:0], 1'b0};
                            st_nxt.dout   = st_r.sh_out[DATA_W-2];
                        end
                    end
                    if (sample_edge && !st_r.first_edge) begin
                        st_nxt.bit_cnt = st_r.bit_cnt + 5'h1;
                        if (st_r.bit_cnt == 5'(DATA_W-1)) begin
                            st_nxt.phase   = ashp_pkg::ST_CMD;
                            st_nxt.bit_cnt = '0;
                            st_nxt.oe      = 1'b0;
                            if (st_r.sel == `ASHP_SEL_DATA) begin
                                // Word stays readable again while ready is high
                                st_nxt.fresh     = 1'b0;
                                st_nxt.read_once = 1'b1;
                            end
                        end
                    end
                end
                default: st_nxt.phase = ashp_pkg::ST_CMD;
            endcase
        end
        if (word_valid_i) begin
            st_nxt.fresh = 1'b1;
        end
        if (st_r.in_rst) begin
            st_nxt.phase = ashp_pkg::ST_CMD;
            st_nxt.fresh = 1'b0;
            st_nxt.oe    = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r        <= '0;
            st_r.in_rst <= 1'b1;
            st_r.s1     <= '1;
            st_r.s2     <= '1;
            st_r.sclk_d <= 1'b1;
            st_r.csn_d  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Write transfers queue ahead of the register file
    ashp_fifo #(.W(11), .D(FIFO_DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (st_r.push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (st_r.wr),
        .out_valid_o (fifo_valid),
        .out_ready_i (wr_ready_i),
        .out_data_o  (fifo_q)
    );

    assign wr_valid_o          = fifo_valid;
    assign wr_sel_o            = fifo_q[10:8];
    assign wr_data_o           = fifo_q[7:0];
    assign dout_o              = st_r.dout;
    assign dout_oe_o           = st_r.oe;
    assign ready_n_o           = !st_r.fresh;
    assign crystal_drive_out_o = st_r.xtal_out;
    assign in_reset_o          = st_r.in_rst;

    // Doubling bit is owned upstream; slow rates only need it clear
    logic unused_dbl;
    assign unused_dbl = double_clock_select_i;

    // Last sampling edge of a read word
    sequence s_word_done;
        active && st_r.phase == ashp_pkg::ST_RD && sample_edge && !st_r.first_edge
            && st_r.bit_cnt == 5'(DATA_W-1);
    endsequence

    // First drive edge of a read word
    sequence s_first_drive;
        active && st_r.phase == ashp_pkg::ST_RD && drive_edge && st_r.first_edge;
    endsequence

    a_drive_idle_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_r.s2.csn |=> !dout_oe_o) else $error("output driven without select");
    a_xtal_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        crystal_mode_i |=> !crystal_drive_out_o) else $error("clock leaked in crystal mode");
    a_new_word_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        word_valid_i && !st_r.in_rst |=> !ready_n_o) else $error("ready not low");
    a_reset_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_r.in_rst && !st_r.s2.rst_n |=> in_reset_o) else $error("reset released early");
    a_exit_needs_clk: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $fell(in_reset_o) |-> $past(st_r.s2.rst_n)
            && $past(st_r.mclk_tmo) != 7'(`ASHP_MCLK_TMO))
        else $error("reset left without pin high and clock running");

    a_read_releases: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_word_done |=> !dout_oe_o) else $error("line held after last bit");
    a_ready_after_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_word_done ##0 (st_r.sel == `ASHP_SEL_DATA && !word_valid_i) |=> ready_n_o)
        else $error("ready not raised after read");
    a_aux_latched: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_first_drive |=> st_r.sh_out[`ASHP_AUX1_BIT] == $past(st_r.s2.aux[1])
            && st_r.sh_out[`ASHP_AUX0_BIT] == $past(st_r.s2.aux[0]))
        else $error("aux levels not in word");
    a_dout_drive_only: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !drive_edge |=> $stable(dout_o)) else $error("data moved off the drive edge");
endmodule

// File: sim/ashp_host.sv
// Host model: drives framed transfers on the serial pins of the port
`timescale 1ns/1ps
`include "ashp_defs.svh"
module ashp_host (
    // Clock
    input  wire logic       clk_i,
    // Serial pins
    output logic            cs_n_o,
    output logic            sclk_o,
    output logic            din_o,
    input  wire logic       dout_i,
    input  wire logic       dout_oe_i,
    // Auxiliary pins
    output logic [1:0]      aux_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o  = 1'b0;
        aux_o  = 2'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    // Read data is taken just before the sampling edge; the port lets go after it
    task automatic frame(input logic idle, input logic [7:0] cmd, input logic [7:0] wd,
                         input logic [1:0] a_first, input logic [1:0] a_late,
                         output logic [23:0] rd);
        int nb;
        tick(1);
        sclk_o = idle;
        aux_o = a_first;
        tick(4);
        cs_n_o = 1'b0;
        tick(4);
        for (int i = 7; i >= 0; i--) begin
            sclk_o = ~idle;
            din_o = cmd[i];
            tick(4);
            sclk_o = idle;
            tick(4);
        end
        nb = cmd[`ASHP_RW_BIT] ? 24 : 8;
        rd = 24'h0;
        for (int i = 0; i < nb; i++) begin
            sclk_o = ~idle;
            din_o = (nb == 8) ? wd[7 - i] : ~din_o;
            tick(4);
            rd = {rd[22:0], dout_oe_i ? dout_i : ~rd[0]};
            sclk_o = idle;
            if (i == 0) aux_o = a_late;
            tick(4);
        end
        cs_n_o = 1'b1;
        tick(4);
        // Clock rests high between frames so tied-low select stays legal
        sclk_o = 1'b1;
        din_o = ~din_o;
    endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the converter serial host port
`timescale 1ns/1ps
module tb_top;
    localparam int DEPTH = 8;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        cs_n, sclk, din, dout, dout_oe, ready_n, cdo, in_rst;
    logic [1:0]  aux;
    logic        mclk = 1'b0;
    logic        mclk_run = 1'b1;
    logic        reset_n = 1'b1;
    logic        xtal = 1'b0;
    logic        dbl = 1'b0;
    logic        word_valid = 1'b0;
    logic [23:0] word = 24'h0;
    logic        wr_valid, wr_ready;
    logic [2:0]  wr_sel;
    logic [7:0]  wr_data;
    logic [23:0] rd, exp;
    logic [10:0] wq[$];
    int          num_errors = 0;
    int          n_checks = 0;
    int          ones;

    always #25 clk_i = ~clk_i;
    initial forever #200 if (mclk_run) mclk = ~mclk;

    ashp_port #(.DATA_W(24), .FIFO_DEPTH(DEPTH)) i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
        .dout_o(dout), .dout_oe_o(dout_oe), .ready_n_o(ready_n),
        .aux_input_0_i(aux[0]), .aux_input_1_i(aux[1]), .master_clock_in_i(mclk),
        .reset_n_i(reset_n), .crystal_mode_i(xtal), .double_clock_select_i(dbl),
        .crystal_drive_out_o(cdo), .in_reset_o(in_rst), .word_valid_i(word_valid),
        .word_data_i(word), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
        .wr_sel_o(wr_sel), .wr_data_o(wr_data));

    ashp_host i_host (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din),
        .dout_i(dout), .dout_oe_i(dout_oe), .aux_o(aux));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        for (int t = 0; t < lim && s !== v; t++) tick(1);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Read of the result register: select 3, read bit set
    task automatic read_word(input logic idle, input logic [1:0] a);
        i_host.frame(idle, 8'h38, 8'h00, a, ~a, rd);
        exp = {word[23:5], a[1], a[0], word[2:0]};
    endtask

    initial begin
        logic [2:0] s;
        logic [7:0] d;
        wr_ready = 1'b0;
        void'($urandom(21978));
        tick(3);
        sys_rst_i = 1'b0;
        chk("in_reset", 24'h1, in_rst);
        chk("ready_n", 24'h1, ready_n);
        wait_lvl(in_rst, 1'b0, 200);
        chk("in_reset", 24'h0, in_rst);
        for (int p = 0; p < 2; p++) begin
            word = 24'($urandom);
            dbl = 1'($urandom);
            word_valid = 1'b1;
            tick(1);
            word_valid = 1'b0;
            wait_lvl(ready_n, 1'b0, 20);
            chk("ready_n", 24'h0, ready_n);
            read_word(p == 0, 2'($urandom));
            chk("rd", exp, rd);
            tick(10);
            chk("ready_n", 24'h1, ready_n);
            read_word(p == 0, 2'($urandom));
            chk("rd again", exp, rd);
        end
        for (int k = 0; k <= DEPTH; k++) begin
            s = 3'($urandom_range(6));
            s = (s >= 3'h3) ? s + 3'h1 : s;
            d = 8'($urandom);
            i_host.frame(1'b1, {1'b0, s, 4'h0}, d, 2'h0, 2'h0, rd);
            if (k < DEPTH) wq.push_back({s, d});
        end
        chk("wr_valid", 24'h1, wr_valid);
        wr_ready = 1'b1;
        while (wq.size() > 0) begin
            wait_lvl(wr_valid, 1'b1, 50);
            chk("write", {13'h0, wq.pop_front()}, {13'h0, wr_sel, wr_data});
            tick(1);
        end
        tick(5);
        chk("wr_valid", 24'h0, wr_valid);
        for (int m = 0; m < 2; m++) begin
            xtal = (m == 0);
            ones = 0;
            tick(4);
            for (int t = 0; t < 40; t++) begin
                tick(1);
                ones += cdo;
            end
            chk("clk out toggles", {23'h0, m == 1}, {23'h0, ones > 0 && ones < 40});
        end
        word = 24'($urandom);
        word_valid = 1'b1;
        tick(1);
        word_valid = 1'b0;
        tick(10);
        mclk_run = 1'b0;
        reset_n = 1'b0;
        // Clock must stay still past the port's clock timeout to count as stopped
        tick(70);
        chk("in_reset", 24'h1, in_rst);
        reset_n = 1'b1;
        tick(30);
        chk("in_reset", 24'h1, in_rst);
        chk("ready_n", 24'h1, ready_n);
        mclk_run = 1'b1;
        wait_lvl(in_rst, 1'b0, 300);
        chk("in_reset", 24'h0, in_rst);
        report_and_stop();
    end

    initial begin
        #3000000;
        num_errors++;
        report_and_stop();
    end
endmodule
